// ### hw/panrb_pkg.sv
// Purpose: Constants for the auto-negotiation register bank
// Assumes: Byte offsets within one port page, port in addr[15:12]
// Notes: Two copper ports, numbered 1 and 2
package panrb_pkg;
    localparam int NPORTS = 2;
    localparam logic [3:0] PORT_FIRST = 4'h1;
    localparam logic [11:0] OFF_CTRL = 12'h100;
    localparam logic [11:0] OFF_ID_LO = 12'h106;
    localparam logic [11:0] OFF_ADV = 12'h108;
    localparam logic [11:0] OFF_LP = 12'h10a;
    localparam logic [11:0] OFF_EXP = 12'h10c;
    localparam logic [15:0] ADV_RESET = 16'h05e1;
    localparam logic [15:0] ADV_WMASK = 16'hadff;
    localparam logic [15:0] LP_RESET = 16'h0000;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam int ADV_NP_BIT = 15;
    localparam int ADV_RF_BIT = 13;
    localparam int ADV_T4_BIT = 9;
    localparam int LP_NP_BIT = 15;
    localparam int LP_ACK_BIT = 14;
    localparam int EXP_PDF_BIT = 4;
    localparam int EXP_LPNP_BIT = 3;
    localparam int EXP_NP_BIT = 2;
    localparam int EXP_PR_BIT = 1;
    localparam int EXP_LPAN_BIT = 0;
    localparam int CTRL_RESTART_BIT = 9;
    typedef logic [15:0] panrb_word_t;
    typedef logic [3:0] panrb_nib_t;
    typedef logic [11:0] panrb_off_t;
endpackage

// ### hw/panrb_flag_if.sv
// Purpose: Event flag carrier between bank and flag cells
// Assumes: All signals on mclk
// Notes: set and clr are one-cycle terms
`timescale 1ns/1ns
`default_nettype none
interface panrb_flag_if;
    logic set;
    logic clr;
    logic q;
    modport owner (input set, input clr, output q);
    modport user (output set, output clr, input q);
endinterface // panrb_flag_if
`default_nettype wire

// ### hw/panrb_lhflag.sv
// Purpose: Latch-high event flag
// Assumes: set and clr from logic on mclk
// Notes: Set wins over a clear in the same cycle
`timescale 1ns/1ns
`default_nettype none
module panrb_lhflag (
    input wire logic mclk,
    input wire logic rst_b,
    panrb_flag_if.owner flag
);
    logic flag_reg;
    logic flag_next;

    assign flag_next = flag.set | (flag_reg & ~flag.clr);
    assign flag.q = flag_reg;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end
endmodule // panrb_lhflag
`default_nettype wire

// ### hw/panrb_sc_bit.sv
// Purpose: Self-clearing command bit
// Assumes: set is a decoded write of 1
// Notes: q is a one-cycle pulse; the bit reads back as 0
`timescale 1ns/1ns
`default_nettype none
module panrb_sc_bit (
    input wire logic mclk,
    input wire logic rst_b,
    panrb_flag_if.owner flag
);
    logic pulse_reg;

    assign flag.q = pulse_reg;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pulse_reg <= 1'b0;
        end else begin
            pulse_reg <= flag.set & ~flag.clr;
        end
    end
endmodule // panrb_sc_bit
`default_nettype wire

// ### hw/panrb_top.sv
// Purpose: Per-port auto-negotiation register bank, ports 1 and 2
// Assumes: Negotiation engine runs on mclk; its strobes need no sync
// Notes: Read data valid only in the cycle after the read strobe
//
// Contract
// - ID low word is fixed, read-only
// - Adv bit 15 next page, writable, reset 0
// - Adv bit 13 remote fault, writable, reset 0
// - Adv pause bits 11:10 writable, reset 01
// - Adv bit 9 always reads zero
// - Adv bits 8:5 writable, reset one
// - Partner bit 14 set once word received
// - Partner word read-only, same encoding
// - Expansion bit 4 latches parallel fault
// - Expansion bit 3 partner next page
// - Expansion bit 2 local next page
// - Expansion bit 1 latches page received
// - Expansion bit 0 partner can negotiate
// - Self-clearing bit restarts auto-negotiation
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module panrb_top #(
    // Arbitrary value, not a real identifier
    parameter panrb_pkg::panrb_word_t ID_LOW = 16'h00a5
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic [1:0] page_rx_stb,
    input wire logic [1:0][15:0] page_rx_word,
    input wire logic [1:0] par_fault_det,
    input wire logic [1:0] lp_an_able,
    output logic [1:0][15:0] adv_word,
    output logic [1:0] an_restart
);
    import panrb_pkg::*;

    // Port hit for the upper address nibble
    function automatic logic port_hit(input panrb_nib_t nib,
                                      input int idx);
        port_hit = (nib == (PORT_FIRST + 4'(idx)));
    endfunction

    // Register select within a port page
    function automatic panrb_word_t read_pick(
        input panrb_off_t off,
        input panrb_word_t id_w,
        input panrb_word_t adv_w,
        input panrb_word_t lp_w,
        input panrb_word_t exp_w
    );
        panrb_word_t res;
        res = WORD_ZERO;
        if (off == OFF_ID_LO) begin
            res = id_w;
        end else if (off == OFF_ADV) begin
            res = adv_w;
        end else if (off == OFF_LP) begin
            res = lp_w;
        end else if (off == OFF_EXP) begin
            res = exp_w;
        end
        read_pick = res;
    endfunction

    // Address split
    panrb_nib_t addr_port;
    panrb_off_t addr_off;
    assign addr_port = reg_addr[15:12];
    assign addr_off = reg_addr[11:0];

    // Offset decode shared by both ports
    logic off_is_ctrl;
    logic off_is_adv;
    logic off_is_exp;
    logic wr_restart_bit;
    assign off_is_ctrl = (addr_off == OFF_CTRL);
    assign off_is_adv = (addr_off == OFF_ADV);
    assign off_is_exp = (addr_off == OFF_EXP);
    assign wr_restart_bit = reg_wdata[CTRL_RESTART_BIT];

    // Per-port read words, merged below
    panrb_word_t port_rd_word [NPORTS];
    logic [NPORTS-1:0] port_sel;

    genvar p;
    generate
        for (p = 0; p < NPORTS; p++) begin : g_port
            // Port decode
            logic sel;
            logic wr_adv;
            logic wr_ctrl;
            logic rd_exp;
            assign sel = port_hit(addr_port, p);
            assign wr_adv = reg_wr & sel & off_is_adv;
            assign wr_ctrl = reg_wr & sel & off_is_ctrl;
            assign rd_exp = reg_rd & sel & off_is_exp;
            assign port_sel[p] = sel;

            // Local advertisement
            panrb_word_t adv_reg;
            panrb_word_t adv_next;
            assign adv_next = wr_adv ? (reg_wdata & ADV_WMASK) : adv_reg;

            always_ff @(posedge mclk or negedge rst_b) begin
                if (!rst_b) begin
                    adv_reg <= ADV_RESET;
                end else begin
                    adv_reg <= adv_next;
                end
            end

            // Restart command, self-clearing
            panrb_flag_if restart_if ();
            assign restart_if.set = wr_ctrl & wr_restart_bit;
            assign restart_if.clr = 1'b0;

            panrb_sc_bit u_restart (
                .mclk (mclk),
                .rst_b (rst_b),
                .flag (restart_if)
            );

            // Partner base page capture
            panrb_word_t lp_reg;
            panrb_word_t lp_next;
            logic ack_reg;
            logic ack_next;
            assign lp_next = page_rx_stb[p] ? page_rx_word[p] : lp_reg;
            assign ack_next = page_rx_stb[p] | (ack_reg & ~restart_if.q);

            always_ff @(posedge mclk or negedge rst_b) begin
                if (!rst_b) begin
                    lp_reg <= LP_RESET;
                    ack_reg <= 1'b0;
                end else begin
                    lp_reg <= lp_next;
                    ack_reg <= ack_next;
                end
            end

            // Partner negotiation ability, sampled level
            logic lpan_reg;
            always_ff @(posedge mclk or negedge rst_b) begin
                if (!rst_b) begin
                    lpan_reg <= 1'b0;
                end else begin
                    lpan_reg <= lp_an_able[p];
                end
            end

            // Latched events
            panrb_flag_if pdf_if ();
            panrb_flag_if prx_if ();
            assign pdf_if.set = par_fault_det[p];
            assign prx_if.set = page_rx_stb[p];
            assign pdf_if.clr = rd_exp;
            assign prx_if.clr = rd_exp;

            panrb_lhflag u_pdf (
                .mclk (mclk),
                .rst_b (rst_b),
                .flag (pdf_if)
            );

            panrb_lhflag u_prx (
                .mclk (mclk),
                .rst_b (rst_b),
                .flag (prx_if)
            );

            // Read views
            panrb_word_t lp_view;
            panrb_word_t exp_view;
            // ack bit over the captured word
            assign lp_view = {lp_reg[LP_NP_BIT], ack_reg,
                              lp_reg[LP_ACK_BIT-1:0]};
            assign exp_view = {11'h000,
                               pdf_if.q,
                               lp_reg[LP_NP_BIT],
                               adv_reg[ADV_NP_BIT],
                               prx_if.q,
                               lpan_reg};

            assign port_rd_word[p] = read_pick(addr_off, ID_LOW, adv_reg,
                                               lp_view, exp_view);

            // Outputs driven from flops
            assign adv_word[p] = adv_reg;
            assign an_restart[p] = restart_if.q;
        end
    endgenerate

    // Read data merge; unmapped or idle reads give zero
    panrb_word_t rd_merge;
    panrb_word_t rdata_reg;
    panrb_word_t rdata_next;
    assign rd_merge = port_sel[0] ? port_rd_word[0] :
                      port_sel[1] ? port_rd_word[1] : WORD_ZERO;
    // Data valid one cycle only, zero otherwise
    assign rdata_next = reg_rd ? rd_merge : WORD_ZERO;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_reg <= WORD_ZERO;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;
endmodule // panrb_top
`default_nettype wire

// ### bench/panrb_asserts.sv
// Purpose: Port checks for the register bank
// Assumes: One clock, async reset
// Notes: Bound to panrb_top
`timescale 1ns/1ns
`default_nettype none
module panrb_asserts import panrb_pkg::*; #(
    parameter panrb_pkg::panrb_word_t ID_LOW = 16'h00a5
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic [1:0] page_rx_stb,
    input wire logic [1:0][15:0] page_rx_word,
    input wire logic [1:0] par_fault_det,
    input wire logic [1:0] lp_an_able,
    input wire logic [1:0][15:0] adv_word,
    input wire logic [1:0] an_restart
);
    wire logic [15:0] a1 = {PORT_FIRST, 12'h000};
    wire logic rd_id = reg_rd && reg_addr == (a1 | OFF_ID_LO);
    wire logic rd_lp = reg_rd && reg_addr == (a1 | OFF_LP);
    wire logic rd_exp = reg_rd && reg_addr == (a1 | OFF_EXP);
    wire logic wr_adv = reg_wr && reg_addr == (a1 | OFF_ADV);
    wire logic wr_ctl = reg_wr && reg_addr == (a1 | OFF_CTRL);
    wire logic wr_rst = wr_ctl && reg_wdata[CTRL_RESTART_BIT];
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == WORD_ZERO)
        else $error("read data not zero when idle");
    a_id_fixed: assert property (rd_id |=> reg_rdata == ID_LOW)
        else $error("identifier word wrong");
    a_adv_write: assert property (wr_adv |=>
        adv_word[0] == ($past(reg_wdata) & ADV_WMASK))
        else $error("advertisement write wrong");
    a_adv_zeros: assert property ((adv_word & ~{2{ADV_WMASK}}) == 0)
        else $error("fixed advertisement bit set");
    a_adv_hold: assert property (!reg_wr |=> $stable(adv_word))
        else $error("advertisement changed without write");
    // Back-to-back restart writes may keep the pulse high
    a_restart_pulse: assert property (wr_rst |=>
        an_restart[0] ##1 (!an_restart[0] || $past(wr_rst)))
        else $error("restart pulse wrong");
    // A restart written beside the page would clear the ack
    a_lp_ack: assert property (page_rx_stb[0] && !reg_wr ##1 !reg_wr
        ##1 rd_lp |=> reg_rdata[LP_ACK_BIT])
        else $error("acknowledge not set");
    a_page_latch: assert property (page_rx_stb[0] ##1 !reg_rd
        ##1 rd_exp |=> reg_rdata[EXP_PR_BIT])
        else $error("page received not latched");
    a_exp_local: assert property (rd_exp |=>
        reg_rdata[EXP_NP_BIT] == $past(adv_word[0][ADV_NP_BIT]) &&
        reg_rdata[15:5] == 11'h000)
        else $error("expansion word wrong");
    c_restart: cover property (an_restart[0]);
    c_page: cover property (page_rx_stb[0]);
    c_fault: cover property (par_fault_det[0] ##[1:4] rd_exp);
endmodule // panrb_asserts
bind panrb_top panrb_asserts #(.ID_LOW(ID_LOW)) u_chk (.mclk(mclk),
    .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .page_rx_stb(page_rx_stb), .page_rx_word(page_rx_word),
    .par_fault_det(par_fault_det), .lp_an_able(lp_an_able),
    .adv_word(adv_word), .an_restart(an_restart));
`default_nettype wire

// ### bench/panrb_partner.sv
// Purpose: Remote link partner on the engine side
// Assumes: Engine strobes on mclk
// Notes: Idle word lines carry a changed pattern
`timescale 1ns/1ns
`default_nettype none
module panrb_partner (
    input wire logic mclk,
    output logic [1:0] page_rx_stb,
    output logic [1:0][15:0] page_rx_word,
    output logic [1:0] par_fault_det,
    output logic [1:0] lp_an_able
);
    initial begin
        page_rx_stb = '0;
        page_rx_word = '0;
        par_fault_det = '0;
        lp_an_able = '0;
    end
    task automatic send(input int p, input logic [15:0] w);
        @(posedge mclk);
        page_rx_stb[p] <= 1'b1;
        page_rx_word[p] <= w;
        @(posedge mclk);
        page_rx_stb[p] <= 1'b0;
        // Stale word must not look valid
        page_rx_word[p] <= ~w;
    endtask
    task automatic fault(input int p);
        @(posedge mclk);
        par_fault_det[p] <= 1'b1;
        @(posedge mclk);
        par_fault_det[p] <= 1'b0;
    endtask
    task automatic set_fault(input int p, input logic v);
        @(posedge mclk);
        par_fault_det[p] <= v;
    endtask
    task automatic able(input int p, input logic v);
        @(posedge mclk);
        lp_an_able[p] <= v;
    endtask
endmodule // panrb_partner
`default_nettype wire

// ### bench/panrb_bench.sv
// Purpose: Bench for the register bank
// Assumes: Partner model drives engine side
// Notes: Port 1 mainly, port 2 for isolation
`timescale 1ns/1ns
`default_nettype none
module panrb_bench;
    import panrb_pkg::*;
    // Arbitrary identifier value
    localparam panrb_word_t ID = 16'h3c5a;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [15:0] reg_addr = '0;
    logic [15:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [1:0] page_rx_stb;
    logic [1:0] par_fault_det;
    logic [1:0] lp_an_able;
    logic [1:0] an_restart;
    logic [1:0][15:0] page_rx_word;
    logic [1:0][15:0] adv_word;
    int fail_count = 0;
    int cmp_count = 0;
    always #20 mclk = ~mclk;
    panrb_top #(.ID_LOW(ID)) dut (.mclk(mclk), .rst_b(rst_b),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .page_rx_stb(page_rx_stb),
        .page_rx_word(page_rx_word), .par_fault_det(par_fault_det),
        .lp_an_able(lp_an_able), .adv_word(adv_word),
        .an_restart(an_restart));
    panrb_partner lp (.mclk(mclk), .page_rx_stb(page_rx_stb),
        .page_rx_word(page_rx_word), .par_fault_det(par_fault_det),
        .lp_an_able(lp_an_able));
    task automatic chk(input panrb_word_t seen, input panrb_word_t exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input panrb_word_t a, input panrb_word_t d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rdc(input panrb_word_t a, input panrb_word_t exp);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task automatic t_reset;
        rdc(16'h1106, ID);
        rdc(16'h2106, ID);
        rdc(16'h1108, 16'h05e1);
        rdc(16'h2108, 16'h05e1);
        rdc(16'h110a, 16'h0000);
        rdc(16'h110c, 16'h0000);
        $display("t_reset done");
    endtask
    task automatic t_adv;
        wr(16'h1108, 16'hffff);
        chk(adv_word[0], 16'hadff);
        chk(adv_word[1], 16'h05e1);
        rdc(16'h2108, 16'h05e1);
        rdc(16'h110c, 16'h0004);
        for (int c = 0; c < 4; c++) begin
            wr(16'h1108, 16'(c) << 10);
            rdc(16'h1108, 16'(c) << 10);
        end
        wr(16'h1106, 16'hffff);
        rdc(16'h1106, ID);
        wr(16'h1108, 16'h05e1);
        $display("t_adv done");
    endtask
    task automatic t_page;
        lp.able(0, 1'b1);
        lp.send(0, 16'h85e1);
        rdc(16'h110a, 16'hc5e1);
        rdc(16'h110c, 16'h000b);
        rdc(16'h110c, 16'h0009);
        lp.fault(0);
        rdc(16'h110c, 16'h0019);
        rdc(16'h110c, 16'h0009);
        $display("t_page done");
    endtask
    task automatic t_restart;
        wr(16'h1100, 16'h0200);
        chk(16'(an_restart), 16'h0001);
        @(posedge mclk);
        #1 chk(16'(an_restart), 16'h0000);
        rdc(16'h1100, 16'h0000);
        rdc(16'h110a, 16'h85e1);
        rdc(16'h3108, 16'h0000);
        $display("t_restart done");
    endtask
    task automatic t_port2;
        lp.send(1, 16'h0c21);
        lp.fault(1);
        rdc(16'h210a, 16'h4c21);
        rdc(16'h110c, 16'h0009);
        rdc(16'h210c, 16'h0012);
        lp.set_fault(1, 1'b1);
        rdc(16'h210c, 16'h0010);
        rdc(16'h210c, 16'h0010);
        lp.set_fault(1, 1'b0);
        rdc(16'h210c, 16'h0010);
        rdc(16'h210c, 16'h0000);
        $display("t_port2 done");
    endtask
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        t_reset;
        t_adv;
        t_page;
        t_restart;
        t_port2;
        wrap_up;
    end
    // Whole run is well under a thousand cycles
    initial begin
        repeat (3000) @(posedge mclk);
        fail_count++;
        wrap_up;
    end
endmodule // panrb_bench
`default_nettype wire
